//--- sep_pkg.sv
// Behaviour
// - All opcode, address and data bytes travel most significant bit first.
// - First eight bits after chip select falls form the opcode.
// - Unknown opcode: ignore input, output floats until next select.
// - Deselected: serial input ignored, serial output floats.
// - Pause pin low holds sequence state, floats output, ignores input.
// - Opcodes x110 set latch, x100 clear latch, x101 read status.
// - Opcodes x001 write status, x011 read array, x010 write array.
// - Latch clears at reset and after every internal write cycle.
// - Clear-latch disables programming whatever the protect pin does.
// - Status bit 0 shows busy, bit 1 shows latch set.
// - Bits 4..6 read zero when idle; all bits read one when busy.
// - Guard bits select none, upper quarter, upper half or whole array.
// - Guard and pin-enable bits change only with latch, over a write cycle.
// - Pin low with enable bit set refuses every status write.
// - Protect pin falling during a selected frame aborts a status write.
// - Guarded array never written; others need latch; status also needs no pin guard.
// - Read: opcode, three address bytes, then data with wrapping increment.
// - Write programs on chip select rising right after last data bit; the code programs on any rise once a whole data byte is in.
// - Page writes increment only low eight address bits, wrapping in page.
// - While busy, only the status read is honoured.
// - Write without latch is ignored until chip select rises.
// - Addresses are 24 bits; bits 23..17 are ignored.
// - Status bit 7 pin enable, 3 guard high, 2 guard low, 1 latch, 0 busy.
// - Link runs with clock polarity and phase zero.
package sep_pkg;

    localparam int unsigned CORE_CLK_HZ = 125_000_000;
    localparam int unsigned WC_TIME_US  = 5000;
    localparam int unsigned WC_CYCLES   = WC_TIME_US * (CORE_CLK_HZ / 1_000_000);
    localparam int unsigned WC_CNT_W    = 20;

    localparam logic [3:0] OP_HI        = 4'h0;
    localparam logic [2:0] OP_SET_LATCH = 3'h6;
    localparam logic [2:0] OP_CLR_LATCH = 3'h4;
    localparam logic [2:0] OP_RD_STATE  = 3'h5;
    localparam logic [2:0] OP_WR_STATE  = 3'h1;
    localparam logic [2:0] OP_RD_ARRAY  = 3'h3;
    localparam logic [2:0] OP_WR_ARRAY  = 3'h2;

    localparam int unsigned ST_BUSY     = 0;
    localparam int unsigned ST_LATCH    = 1;
    localparam int unsigned ST_GUARD_LO = 2;
    localparam int unsigned ST_GUARD_HI = 3;
    localparam int unsigned ST_PIN_EN   = 7;
    localparam logic [7:0]  ST_BUSY_VIEW = 8'hFF;

    localparam logic [16:0] GUARD_QTR_BASE  = 17'h18000;
    localparam logic [16:0] GUARD_HALF_BASE = 17'h10000;

    localparam logic [4:0] BYTE_LAST = 5'h07;
    localparam logic [4:0] ADDR_LAST = 5'h17;
    localparam logic [7:0] PAGE_LAST = 8'hFF;

    localparam logic       PIN_EN_RESET = 1'h0;
    localparam logic [1:0] GUARD_RESET  = 2'h0;
    localparam logic [2:0] SYNC_RESET   = 3'h6;

    typedef enum logic [2:0] {
        LK_OPCODE, LK_ADDR, LK_READ, LK_WRDATA, LK_WRSTATE, LK_RDSTATE, LK_IGNORE
    } sep_link_t;

    typedef enum logic [1:0] {CR_IDLE, CR_PROG, CR_WAIT} sep_core_t;

    typedef enum logic [2:0] {
        CMD_NONE, CMD_SET_LATCH, CMD_CLR_LATCH, CMD_WR_STATE, CMD_WR_ARRAY
    } sep_cmd_t;

endpackage

//--- sep_cmd_protect.sv
`timescale 1ns/1ps
`default_nettype none
module sep_cmd_protect
    import sep_pkg::*;
#(
    parameter int unsigned WcCycles = WC_CYCLES
)
(
    // system
    input  wire logic        core_clk,
    input  wire logic        nrst,
    // serial link
    input  wire logic        sck,
    input  wire logic        csN,
    input  wire logic        serialIn,
    input  wire logic        pauseN,
    output logic             serialOut,
    output logic             serialOutOeN,
    // write guard pin
    input  wire logic        protectPinN,
    // array read port, sck domain
    output logic [16:0]      arrRdAddr,
    input  wire logic [7:0]  arrRdData,
    // array write port, core domain
    output logic             arrWrEn,
    output logic [16:0]      arrWrAddr,
    output logic [7:0]       arrWrData
);

    // sck domain
    sep_link_t   linkSt_q;
    logic [4:0]  bitCnt_q;
    logic [23:0] sh_q;
    logic [16:0] rdAddr_q;
    logic        commitReq_q;
    logic [7:0]  stSync1_q;
    logic [7:0]  stSync2_q;
    sep_cmd_t    cmdKind_q;
    logic [7:0]  stateData_q;
    logic [16:0] pagePtr_q;
    logic [7:0]  pageBuf_q [256];
    logic [255:0] pageValid_q;
    logic [7:0]  outSh_q;
    logic        serialOut_q;
    logic        drive_q;
    logic        byteEnd;
    logic [7:0]  rxByte;
    logic [16:0] addrIn;
    logic        linkBusy;
    logic        linkLatch;
    sep_link_t   opNext;
    sep_cmd_t    opCmd;
    logic        opArm;

    // core domain
    logic [2:0]  sync1_q;
    logic [2:0]  sync2_q;
    logic        csS;
    logic        protS;
    logic        reqS;
    logic        csPrev_q;
    logic        protPrev_q;
    logic        armed_q;
    logic        abort_q;
    logic        commit;
    sep_core_t   coreSt_q;
    logic        latch_q;
    logic        pinEn_q;
    logic [1:0]  guard_q;
    logic [7:0]  idx_q;
    logic [WC_CNT_W-1:0] wcCnt_q;
    logic [WC_CNT_W-1:0] wcLast;
    logic        stPend_q;
    logic [7:0]  stNew_q;
    logic [7:0]  stateView_q;
    logic [7:0]  stateView;
    logic        busy;
    logic        hwProt;
    logic        pageGuarded;
    logic [16:0] pageBase;

    assign byteEnd   = bitCnt_q == BYTE_LAST;
    assign rxByte    = {sh_q[6:0], serialIn};
    assign addrIn    = {sh_q[15:0], serialIn};
    assign linkBusy  = stSync2_q[ST_BUSY];
    assign linkLatch = stSync2_q[ST_LATCH];

    // opcode decode, bit 3 ignored
    always_comb
    begin
        opNext = LK_IGNORE;
        opCmd  = CMD_NONE;
        opArm  = 1'b0;
        if (rxByte[7:4] == OP_HI)
        begin
            unique case (rxByte[2:0])
                OP_RD_STATE:
                    opNext = LK_RDSTATE;
                OP_SET_LATCH:
                    if (!linkBusy)
                    begin
                        opCmd = CMD_SET_LATCH;
                        opArm = 1'b1;
                    end
                OP_CLR_LATCH:
                    if (!linkBusy)
                    begin
                        opCmd = CMD_CLR_LATCH;
                        opArm = 1'b1;
                    end
                OP_WR_STATE:
                    if (!linkBusy && linkLatch)
                    begin
                        opCmd  = CMD_WR_STATE;
                        opNext = LK_WRSTATE;
                    end
                OP_RD_ARRAY:
                    if (!linkBusy)
                        opNext = LK_ADDR;
                OP_WR_ARRAY:
                    if (!linkBusy && linkLatch)
                    begin
                        opCmd  = CMD_WR_ARRAY;
                        opNext = LK_ADDR;
                    end
                default:
                    opNext = LK_IGNORE;
            endcase
        end
    end

    // frame sequencer, sampled on rising sck
    always_ff @(posedge sck or posedge csN)
    begin
        if (csN)
        begin
            linkSt_q    <= LK_OPCODE;
            bitCnt_q    <= '0;
            sh_q        <= '0;
            rdAddr_q    <= '0;
            commitReq_q <= 1'b0;
        end
        else if (pauseN)
        begin
            sh_q     <= {sh_q[22:0], serialIn};
            bitCnt_q <= bitCnt_q + 5'h01;
            unique case (linkSt_q)
                LK_OPCODE:
                    if (byteEnd)
                    begin
                        bitCnt_q    <= '0;
                        linkSt_q    <= opNext;
                        commitReq_q <= opArm;
                    end
                LK_ADDR:
                    if (bitCnt_q == ADDR_LAST)
                    begin
                        bitCnt_q <= '0;
                        rdAddr_q <= addrIn;
                        linkSt_q <= (cmdKind_q == CMD_WR_ARRAY) ? LK_WRDATA : LK_READ;
                    end
                LK_READ:
                    if (byteEnd)
                    begin
                        bitCnt_q <= '0;
                        rdAddr_q <= rdAddr_q + 17'h00001;
                    end
                LK_WRDATA:
                    if (byteEnd)
                    begin
                        bitCnt_q    <= '0;
                        commitReq_q <= 1'b1;
                    end
                LK_WRSTATE:
                    if (byteEnd)
                    begin
                        bitCnt_q    <= '0;
                        commitReq_q <= 1'b1;
                        linkSt_q    <= LK_IGNORE;
                    end
                LK_RDSTATE:
                    if (byteEnd)
                        bitCnt_q <= '0;
                LK_IGNORE:
                    bitCnt_q <= '0;
            endcase
        end
    end

    // status view into the link domain, refreshed within a frame
    always_ff @(posedge sck or posedge csN)
    begin
        if (csN)
        begin
            stSync1_q <= '0;
            stSync2_q <= '0;
        end
        else
        begin
            stSync1_q <= stateView_q;
            stSync2_q <= stSync1_q;
        end
    end

    // frame payload, read by the core only after chip select rises
    always_ff @(posedge sck)
    begin
        if (!csN && pauseN)
        begin
            if (linkSt_q == LK_OPCODE && byteEnd)
            begin
                cmdKind_q <= opCmd;
                if (opCmd == CMD_WR_ARRAY)
                    pageValid_q <= '0;
            end
            if (linkSt_q == LK_ADDR && bitCnt_q == ADDR_LAST)
                pagePtr_q <= addrIn;
            if (linkSt_q == LK_WRDATA && byteEnd)
            begin
                pageBuf_q[pagePtr_q[7:0]]   <= rxByte;
                pageValid_q[pagePtr_q[7:0]] <= 1'b1;
                pagePtr_q[7:0]              <= pagePtr_q[7:0] + 8'h01;
            end
            if (linkSt_q == LK_WRSTATE && byteEnd)
                stateData_q <= rxByte;
        end
    end

    // output shifter, changes on falling sck
    always_ff @(negedge sck or posedge csN)
    begin
        if (csN)
        begin
            outSh_q     <= '0;
            serialOut_q <= 1'b0;
            drive_q     <= 1'b0;
        end
        else if (pauseN)
        begin
            if ((linkSt_q == LK_READ || linkSt_q == LK_RDSTATE) && bitCnt_q == 5'h00)
            begin
                drive_q <= 1'b1;
                if (linkSt_q == LK_READ)
                begin
                    serialOut_q <= arrRdData[7];
                    outSh_q     <= {arrRdData[6:0], 1'b0};
                end
                else
                begin
                    serialOut_q <= stSync2_q[7];
                    outSh_q     <= {stSync2_q[6:0], 1'b0};
                end
            end
            else
            begin
                serialOut_q <= outSh_q[7];
                outSh_q     <= {outSh_q[6:0], 1'b0};
            end
        end
    end

    assign serialOut    = serialOut_q;
    assign serialOutOeN = csN | ~drive_q | ~pauseN;
    assign arrRdAddr    = rdAddr_q;

    // core side: pin and request synchronisers
    always_ff @(posedge core_clk)
    begin
        if (!nrst)
        begin
            sync1_q <= SYNC_RESET;
            sync2_q <= SYNC_RESET;
        end
        else
        begin
            sync1_q <= {csN, protectPinN, commitReq_q};
            sync2_q <= sync1_q;
        end
    end

    assign csS    = sync2_q[2];
    assign protS  = sync2_q[1];
    assign reqS   = sync2_q[0];
    assign commit = csS && !csPrev_q && (armed_q || reqS);
    assign busy   = coreSt_q != CR_IDLE;
    assign hwProt = pinEn_q && !protS;
    assign wcLast = WC_CNT_W'(WcCycles - 1);
    assign pageBase = {pagePtr_q[16:8], 8'h00};
    assign pageGuarded = (guard_q == 2'h3)
                      || (guard_q == 2'h2 && pageBase >= GUARD_HALF_BASE)
                      || (guard_q == 2'h1 && pageBase >= GUARD_QTR_BASE);

    // frame watch: pending request and protect-pin abort
    always_ff @(posedge core_clk)
    begin
        if (!nrst)
        begin
            csPrev_q   <= 1'b1;
            protPrev_q <= 1'b1;
            armed_q    <= 1'b0;
            abort_q    <= 1'b0;
        end
        else
        begin
            csPrev_q   <= csS;
            protPrev_q <= protS;
            if (csS)
            begin
                armed_q <= 1'b0;
                abort_q <= 1'b0;
            end
            else
            begin
                armed_q <= armed_q | reqS;
                abort_q <= abort_q | (protPrev_q & ~protS);
            end
        end
    end

    // command execution and internal write cycle
    always_ff @(posedge core_clk)
    begin
        if (!nrst)
        begin
            coreSt_q <= CR_IDLE;
            latch_q  <= 1'b0;
            pinEn_q  <= PIN_EN_RESET;
            guard_q  <= GUARD_RESET;
            idx_q    <= '0;
            wcCnt_q  <= '0;
            stPend_q <= 1'b0;
            stNew_q  <= '0;
        end
        else
        begin
            unique case (coreSt_q)
                CR_IDLE:
                    if (commit)
                    begin
                        unique case (cmdKind_q)
                            CMD_SET_LATCH:
                                latch_q <= 1'b1;
                            CMD_CLR_LATCH:
                                latch_q <= 1'b0;
                            CMD_WR_STATE:
                                if (latch_q && !hwProt && !abort_q)
                                begin
                                    stPend_q <= 1'b1;
                                    stNew_q  <= stateData_q;
                                    wcCnt_q  <= '0;
                                    coreSt_q <= CR_WAIT;
                                end
                            CMD_WR_ARRAY:
                                if (latch_q && !pageGuarded)
                                begin
                                    idx_q    <= '0;
                                    coreSt_q <= CR_PROG;
                                end
                            default:
                                latch_q <= latch_q;
                        endcase
                    end
                CR_PROG:
                begin
                    idx_q <= idx_q + 8'h01;
                    if (idx_q == PAGE_LAST)
                    begin
                        wcCnt_q  <= '0;
                        coreSt_q <= CR_WAIT;
                    end
                end
                CR_WAIT:
                    if (wcCnt_q == wcLast)
                    begin
                        coreSt_q <= CR_IDLE;
                        latch_q  <= 1'b0;
                        stPend_q <= 1'b0;
                        if (stPend_q)
                        begin
                            pinEn_q <= stNew_q[ST_PIN_EN];
                            guard_q <= {stNew_q[ST_GUARD_HI], stNew_q[ST_GUARD_LO]};
                        end
                    end
                    else
                        wcCnt_q <= wcCnt_q + 1'b1;
            endcase
        end
    end

    // page copy into the array
    always_ff @(posedge core_clk)
    begin
        if (!nrst)
        begin
            arrWrEn   <= 1'b0;
            arrWrAddr <= '0;
            arrWrData <= '0;
        end
        else
        begin
            arrWrEn   <= (coreSt_q == CR_PROG) && pageValid_q[idx_q];
            arrWrAddr <= {pagePtr_q[16:8], idx_q};
            arrWrData <= pageBuf_q[idx_q];
        end
    end

    // status byte as read back
    always_comb
    begin
        stateView              = '0;
        stateView[ST_PIN_EN]   = pinEn_q;
        stateView[ST_GUARD_HI] = guard_q[1];
        stateView[ST_GUARD_LO] = guard_q[0];
        stateView[ST_LATCH]    = latch_q;
        stateView[ST_BUSY]     = busy;
        if (busy)
            stateView = ST_BUSY_VIEW;
    end

    always_ff @(posedge core_clk)
    begin
        if (!nrst)
            stateView_q <= '0;
        else
            stateView_q <= stateView;
    end

endmodule
`default_nettype wire

//--- sep_cmd_protect_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module sep_cmd_protect_checker
    import sep_pkg::*;
#(
    parameter int unsigned WcCycles = WC_CYCLES
)
(
    // system
    input wire logic        core_clk,
    input wire logic        nrst,
    // serial link
    input wire logic        sck,
    input wire logic        csN,
    input wire logic        serialIn,
    input wire logic        pauseN,
    input wire logic        serialOut,
    input wire logic        serialOutOeN,
    input wire logic        protectPinN,
    // array
    input wire logic [16:0] arrRdAddr,
    input wire logic [7:0]  arrRdData,
    input wire logic        arrWrEn,
    input wire logic [16:0] arrWrAddr,
    input wire logic [7:0]  arrWrData
);
    logic [3:0] bitCnt_q;
    logic [7:0] opSeen_q;
    logic       opDone;
    logic       opBad;
    logic       opQuiet;

    // opcode as seen on the wire
    always_ff @(posedge sck or posedge csN)
    begin
        if (csN)
        begin
            bitCnt_q <= 4'h0;
            opSeen_q <= 8'h00;
        end
        else if (pauseN && bitCnt_q < 4'h8)
        begin
            bitCnt_q <= bitCnt_q + 4'h1;
            opSeen_q <= {opSeen_q[6:0], serialIn};
        end
    end

    assign opDone  = bitCnt_q == 4'h8;
    assign opBad   = opSeen_q[7:4] != OP_HI || opSeen_q[2:0] == 3'h0 || opSeen_q[2:0] == 3'h7;
    assign opQuiet = opSeen_q[2:0] != OP_RD_STATE && opSeen_q[2:0] != OP_RD_ARRAY;

    a_deselect_float: assert property (@(posedge core_clk) disable iff (!nrst)
        csN |-> serialOutOeN) else $error("output driven while deselected");
    a_pause_float: assert property (@(posedge core_clk) disable iff (!nrst)
        !csN && !pauseN |-> serialOutOeN) else $error("output driven while paused");
    a_opcode_first: assert property (@(posedge core_clk) disable iff (!nrst)
        !csN && !opDone |-> serialOutOeN) else $error("output driven before opcode");
    a_bad_opcode: assert property (@(posedge core_clk) disable iff (!nrst)
        !csN && opDone && opBad |-> serialOutOeN) else $error("output after bad opcode");
    a_cmd_quiet: assert property (@(posedge core_clk) disable iff (!nrst)
        !csN && opDone && opQuiet |-> serialOutOeN) else $error("output on silent command");
    a_out_on_fall: assert property (@(posedge core_clk) disable iff (!nrst)
        !csN && $changed(serialOut) |-> !sck) else $error("output moved with sck high");
    a_page_stay: assert property (@(posedge core_clk) disable iff (!nrst)
        arrWrEn && $past(arrWrEn) |-> arrWrAddr[16:8] == $past(arrWrAddr[16:8]))
        else $error("page write left its page");
    a_reset_no_write: assert property (@(posedge core_clk) disable iff (!nrst)
        $rose(nrst) |-> !arrWrEn [*8]) else $error("write right after reset");
endmodule

bind sep_cmd_protect sep_cmd_protect_checker #(.WcCycles(WcCycles)) chk_u (
    .core_clk(core_clk), .nrst(nrst), .sck(sck), .csN(csN), .serialIn(serialIn),
    .pauseN(pauseN), .serialOut(serialOut), .serialOutOeN(serialOutOeN),
    .protectPinN(protectPinN), .arrRdAddr(arrRdAddr), .arrRdData(arrRdData),
    .arrWrEn(arrWrEn), .arrWrAddr(arrWrAddr), .arrWrData(arrWrData));
`default_nettype wire

//--- sep_spi_master.sv
`timescale 1ns/1ps
`default_nettype none
module sep_spi_master
(
    // serial link
    output logic      sck,
    output logic      csN,
    output logic      serialIn,
    output logic      pauseN,
    input  wire logic serialOut,
    input  wire logic serialOutOeN
);
    logic lastBit;

    initial
    begin
        sck      = 1'b0;
        csN      = 1'b1;
        serialIn = 1'b1;
        pauseN   = 1'b1;
        lastBit  = 1'b0;
    end

    // select 3 ns off-grid, so each call shifts sck edges 3 ns against core edges
    task automatic start();
        #3 csN = 1'b0;
        #32;
    endtask

    // mode 0, msb first, master samples on rising sck
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--)
        begin
            serialIn = tx[i];
            #32 sck = 1'b1;
            rx[i] = serialOutOeN ? ~lastBit : serialOut;
            lastBit = rx[i];
            #32 sck = 1'b0;
        end
    endtask

    // deselect in the low phase after the last bit
    task automatic stop();
        #16 csN = 1'b1;
        serialIn = ~serialIn;
        #200;
    endtask

    // pause and resume only while sck is low
    task automatic hold(input logic on);
        #16 pauseN = !on;
        serialIn = ~serialIn;
        #16;
    endtask
endmodule
`default_nettype wire

//--- sep_cmd_protect_bench.sv
`timescale 1ns/1ps
`default_nettype none
module sep_cmd_protect_bench
    import sep_pkg::*;
();
    logic        core_clk;
    logic        nrst;
    logic        protectPinN;
    wire         sck, csN, serialIn, pauseN, serialOut, serialOutOeN;
    logic [16:0] arrRdAddr, arrWrAddr;
    logic [7:0]  arrRdData, arrWrData;
    logic        arrWrEn;
    logic [7:0]  mem [0:131071];
    logic [7:0]  pg [3];
    logic [7:0]  rx;
    int          err_total;
    int          checks;

    sep_cmd_protect #(.WcCycles(64)) dut_u (
        .core_clk(core_clk), .nrst(nrst), .sck(sck), .csN(csN), .serialIn(serialIn),
        .pauseN(pauseN), .serialOut(serialOut), .serialOutOeN(serialOutOeN),
        .protectPinN(protectPinN), .arrRdAddr(arrRdAddr), .arrRdData(arrRdData),
        .arrWrEn(arrWrEn), .arrWrAddr(arrWrAddr), .arrWrData(arrWrData));

    sep_spi_master master_u (
        .sck(sck), .csN(csN), .serialIn(serialIn), .pauseN(pauseN),
        .serialOut(serialOut), .serialOutOeN(serialOutOeN));

    // external array: combinational read, one write per core cycle
    assign arrRdData = mem[arrRdAddr];
    always @(posedge core_clk)
    begin
        if (arrWrEn === 1'b1)
            mem[arrWrAddr] <= arrWrData;
    end

    initial
    begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    task automatic finish_test();
        $display("checks %0d err_total %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic frame1(input logic [7:0] op);
        master_u.start();
        master_u.xfer(op, rx);
        master_u.stop();
    endtask

    task automatic rd_state(output logic [7:0] s);
        master_u.start();
        master_u.xfer(8'h05, rx);
        master_u.xfer(8'h00, s);
        master_u.stop();
    endtask

    task automatic send_addr(input logic [7:0] op, input logic [23:0] a);
        master_u.start();
        master_u.xfer(op, rx);
        for (int i = 2; i >= 0; i--)
            master_u.xfer(a[i*8 +: 8], rx);
    endtask

    task automatic wr_array(input logic [23:0] a, input int n);
        send_addr(8'h02, a);
        for (int i = 0; i < n; i++)
            master_u.xfer(pg[i], rx);
        master_u.stop();
    endtask

    task automatic wr_state(input logic [7:0] v);
        frame1(8'h06);
        master_u.start();
        master_u.xfer(8'h01, rx);
        master_u.xfer(v, rx);
        master_u.stop();
    endtask

    task automatic wait_ready();
        logic [7:0] s;
        int         n;
        s = 8'hFF;
        n = 0;
        while (s[0] !== 1'b0 && n < 60)
        begin
            rd_state(s);
            n++;
        end
        if (s[0] !== 1'b0)
        begin
            err_total++;
            finish_test();
        end
    endtask

    task automatic s_latch();
        logic [7:0] s;
        rd_state(s);
        check("idle status", s, 8'h00);
        frame1(8'h0E);
        rd_state(s);
        check("latch set", s, 8'h02);
        @(negedge core_clk) protectPinN = 1'b0;
        frame1(8'h04);
        rd_state(s);
        check("latch cleared", s, 8'h00);
        frame1(8'h16);
        rd_state(s);
        check("bad opcode", s, 8'h00);
        @(negedge core_clk) protectPinN = 1'b1;
    endtask

    task automatic s_page();
        logic [7:0] s;
        pg[0] = 8'h77;
        wr_array(24'h000010, 1);
        rd_state(s);
        check("no latch write", s, 8'h00);
        check("no latch mem", mem[17'h00010], 8'h00);
        pg = '{8'hA5, 8'h3C, 8'h96};
        mem[0] = 8'h5A;
        frame1(8'h06);
        wr_array(24'h01FFFE, 3);
        rd_state(s);
        check("busy view", s, ST_BUSY_VIEW);
        wr_array(24'h000020, 1);
        wait_ready();
        rd_state(s);
        check("latch auto clear", s, 8'h00);
        check("busy ignore", mem[17'h00020], 8'h00);
        check("page end", mem[17'h1FFFF], 8'h3C);
        check("page wrap", mem[17'h1FF00], 8'h96);
        send_addr(8'h03, 24'hFFFFFE);
        master_u.xfer(8'h00, s);
        check("read first", s, 8'hA5);
        master_u.hold(1'b1);
        check("paused float", {7'h00, serialOutOeN}, 8'h01);
        master_u.hold(1'b0);
        master_u.xfer(8'h00, s);
        check("read next", s, 8'h3C);
        master_u.xfer(8'h00, s);
        check("read wrap", s, 8'h5A);
        master_u.stop();
    endtask

    task automatic s_guard();
        logic [7:0]  s;
        logic [7:0]  old;
        logic [16:0] ga;
        for (int g = 1; g <= 3; g++)
        begin
            ga = g == 1 ? 17'h18000 : g == 2 ? 17'h10000 : 17'h00000;
            wr_state(8'(g << 2));
            wait_ready();
            rd_state(s);
            check("guard level", s, 8'(g << 2));
            old = mem[ga];
            pg[0] = 8'(g);
            frame1(8'h06);
            wr_array({7'h00, ga}, 1);
            rd_state(s);
            check("guarded latch", s, 8'(g << 2) | 8'h02);
            check("guarded mem", mem[ga], old);
            if (g < 3)
            begin
                wr_array({7'h00, ga - 17'h1}, 1);
                wait_ready();
                check("free mem", mem[ga - 17'h1], 8'(g));
            end
        end
        wr_state(8'h00);
        wait_ready();
    endtask

    task automatic s_pin();
        logic [7:0] s;
        wr_state(8'h80);
        wait_ready();
        @(negedge core_clk) protectPinN = 1'b0;
        wr_state(8'h00);
        rd_state(s);
        check("pin guard", s, 8'h82);
        @(negedge core_clk) protectPinN = 1'b1;
        master_u.start();
        master_u.xfer(8'h01, rx);
        master_u.xfer(8'h00, rx);
        @(negedge core_clk) protectPinN = 1'b0;
        repeat (4) @(negedge core_clk);
        protectPinN = 1'b1;
        repeat (4) @(negedge core_clk);
        master_u.stop();
        rd_state(s);
        check("pin abort", s, 8'h82);
        wr_state(8'h00);
        wait_ready();
        rd_state(s);
        check("pin released", s, 8'h00);
    endtask

    initial
    begin
        nrst        = 1'b0;
        protectPinN = 1'b1;
        err_total   = 0;
        checks      = 0;
        foreach (mem[i])
            mem[i] = 8'h00;
        repeat (10) @(negedge core_clk);
        nrst = 1'b1;
        repeat (4) @(negedge core_clk);
        s_latch();
        s_page();
        s_guard();
        s_pin();
        finish_test();
    end

    initial
    begin
        #400000;
        err_total++;
        finish_test();
    end
endmodule
`default_nettype wire
